/* File: lng_pkg.sv */
// Shared constants and types for the luma noise and gamma stage
package lng_pkg;

    localparam int ADDR_W     = 6;
    localparam int PT_NUM     = 7;
    localparam int GAMMA_REGS = 14;

    // Register offsets
    localparam logic [5:0] ADDR_NR_GAIN = 6'h23;
    localparam logic [5:0] ADDR_NR_THR  = 6'h24;
    localparam logic [5:0] ADDR_NR_MODE = 6'h25;
    localparam logic [5:0] ADDR_GAMMA_0 = 6'h26;
    localparam logic [5:0] ADDR_GAMMA_N = 6'h33;
    localparam logic [5:0] ADDR_BRIGHT  = 6'h34;
    localparam logic [5:0] ADDR_OCLK    = 6'h35;
    localparam logic [5:0] ADDR_GCTRL   = 6'h36;

    // Field positions
    localparam int BGAIN_LSB = 0;
    localparam int IGAIN_LSB = 4;
    localparam int THR_LSB   = 0;
    localparam int BWIDE_BIT = 6;
    localparam int BBIG_BIT  = 7;
    localparam int BAND_LSB  = 0;
    localparam int MODE_BIT  = 3;
    localparam int OFFS_LSB  = 4;
    localparam int CLKO_BIT  = 1;
    localparam int GEN_BIT   = 0;
    localparam int GSEL_BIT  = 1;

    // Values after reset
    localparam logic [7:0] NR_GAIN_RST = 8'h00;
    localparam logic [7:0] NR_THR_RST  = 8'h00;
    localparam logic [7:0] NR_MODE_RST = 8'h00;
    localparam logic [7:0] OCLK_RST    = 8'h78;
    localparam logic [7:0] GCTRL_RST   = 8'h00;
    localparam logic [GAMMA_REGS-1:0][7:0] GAMMA_RST = {
        8'he0, 8'hc0, 8'ha0, 8'h80, 8'h60, 8'h40, 8'h20,
        8'he0, 8'hc0, 8'ha0, 8'h80, 8'h60, 8'h40, 8'h20};

    // Fixed curve ends, gain and block arithmetic
    localparam logic [7:0] FIX_LO      = 8'h10;
    localparam logic [7:0] FIX_HI      = 8'hf0;
    localparam logic [3:0] GAIN_MAX    = 4'h8;
    localparam int         NR_SHIFT    = 3;
    localparam int         SH_SHIFT    = 4;
    localparam logic [3:0] MASK_SMALL  = 4'h7;
    localparam logic [3:0] MASK_BIG    = 4'hf;
    localparam logic [3:0] EDGE_NARROW = 4'h1;
    localparam logic [3:0] EDGE_WIDE   = 4'h2;
    localparam logic [2:0] DIV_TOP     = 3'h7;

    typedef struct packed {
        logic       valid;
        logic       active;
        logic       vsync_b;
        logic [7:0] luma;
        logic [7:0] chroma;
    } lng_pin_t;

    typedef enum logic [0:0] {
        BR_IDLE = 1'b0,
        BR_DIV  = 1'b1
    } lng_br_t;

endpackage

/* File: lng_gamma.sv */
// Two-curve gamma lookup with linear interpolation on luma
`timescale 1ns/100ps
module lng_gamma (
    input  wire logic                                i_mclk,
    input  wire logic                                i_rst_b,
    input  wire logic                                i_valid,
    input  wire logic [7:0]                          i_luma,
    input  wire logic                                i_enable,
    input  wire logic                                i_sel_curve,
    input  wire logic [lng_pkg::GAMMA_REGS-1:0][7:0] i_points,
    output wire logic                                o_valid,
    output wire logic [7:0]                          o_luma
);
    import lng_pkg::*;

    typedef struct packed {
        logic       valid;
        logic [7:0] luma;
    } lng_gst_t;

    lng_gst_t               st_ff;
    lng_gst_t               nxt_st;
    logic [PT_NUM-1:0][7:0] curve;
    logic [7:0]             pt_val;

    function automatic logic [7:0] interp(input logic [7:0] x,
                                          input logic [PT_NUM-1:0][7:0] p);
        logic [7:0]         ylo;
        logic [7:0]         yhi;
        logic [4:0]         fr;
        logic               half;
        logic signed [15:0] prod;
        logic signed [15:0] step;
        logic signed [9:0]  sum;
        ylo  = FIX_LO;
        yhi  = p[0];
        fr   = {1'b0, x[3:0]};
        half = 1'b1;
        if (x[7:5] == 3'h7) begin
            ylo = p[PT_NUM-1];
            yhi = FIX_HI;
        end else if (x[7:5] != 3'h0) begin
            ylo  = p[x[7:5] - 3'h1];
            yhi  = p[x[7:5]];
            fr   = x[4:0];
            half = 1'b0;
        end
        prod = ($signed({2'b00, yhi}) - $signed({2'b00, ylo}))
               * $signed({1'b0, fr});
        step = prod >>> (half ? 4 : 5);
        sum  = $signed({2'b00, ylo}) + step[9:0];
        if (x < FIX_LO || x >= FIX_HI) begin
            return x;
        end
        return sum[7:0];
    endfunction

    // Exactly one curve feeds the interpolator
    assign curve  = i_sel_curve ? i_points[GAMMA_REGS-1:PT_NUM]
                            : i_points[PT_NUM-1:0];
    assign pt_val = curve[i_luma[7:5] - 3'h1];

    always_comb begin
        nxt_st.valid = i_valid;
        nxt_st.luma  = i_luma;
        if (i_valid && i_enable) begin
            nxt_st.luma = interp(i_luma, curve);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_valid = st_ff.valid;
    assign o_luma  = st_ff.luma;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    a_gamma_fixed: assert property (
        (i_valid && i_enable && (i_luma < FIX_LO || i_luma >= FIX_HI))
        |=> o_luma == $past(i_luma))
        else $error("fixed gamma point moved");

    a_gamma_point: assert property (
        (i_valid && i_enable && i_luma[4:0] == 5'h00 && i_luma[7:5] != 3'h0)
        |=> o_luma == $past(pt_val))
        else $error("gamma output differs from curve point");

    a_gamma_off: assert property (
        (i_valid && !i_enable) |=> (o_valid && o_luma == $past(i_luma)))
        else $error("gamma applied while disabled");

endmodule

/* File: lng_top.sv */
// Luma noise reduction, gamma correction and brightness monitor stage
//
// What this block does
// - Noise mode subtracts gained sub-threshold band part
// - Sharpen mode adds half-range gain above threshold
// - Band select picks filter feeding noise processing
// - Mode bit: zero removes noise, one sharpens
// - Block offset shifts grid by 0-15 pixels
// - Gamma touches luma only, chroma passes
// - Two curves held, exactly one applied
// - Seven programmable points, linear interpolation between
// - Points 0, 16, 240, 255 are fixed
// - Fourteen point registers at 26H through 33H
// - Read-only brightness at 34H, active video only
// - Brightness updates on each vertical sync fall with no division running
// - Clock output enable bit gates clock pin
// - Enable works only with PLL on, oversampling on
// - Six-bit threshold separates noise from detail
// - Border width bit: four or two pixels
// - Block size bit: 16x16 or 8x8 blocks
// - Border gain uses same ranges and behaviour
`timescale 1ns/100ps
module lng_top #(
    parameter int SUM_W = 28,
    parameter int CNT_W = 20
) (
    input  wire logic                       i_mclk,
    input  wire logic                       i_rst_b,
    input  wire logic                       i_pix_valid,
    input  wire logic                       i_active,
    input  wire logic                       i_vsync_b,
    input  wire logic [7:0]                 i_luma,
    input  wire logic [7:0]                 i_chroma,
    input  wire logic [lng_pkg::ADDR_W-1:0] i_reg_addr,
    input  wire logic [7:0]                 i_reg_wdata,
    input  wire logic                       i_reg_wr,
    input  wire logic                       i_pll_control_bit,
    input  wire logic                       i_oversampling_control_bit,
    output wire logic                       o_valid,
    output wire logic [7:0]                 o_luma,
    output wire logic [7:0]                 o_chroma,
    output wire logic [7:0]                 o_reg_rdata,
    output wire logic                       o_clock_out_enable
);
    import lng_pkg::*;

    if (SUM_W < CNT_W + 8 || CNT_W < 1) begin : g_chk
        $error("lng_top: SUM_W must be at least CNT_W + 8");
    end

    typedef struct packed {
        lng_pin_t                   syn1;
        lng_pin_t                   syn2;
        logic                       act_d;
        logic                       vs_d;
        logic [7:0]                 p1;
        logic [7:0]                 p2;
        logic [3:0]                 hpos;
        logic [3:0]                 vpos;
        logic [7:0]                 gain;
        logic [7:0]                 thr;
        logic [7:0]                 mode;
        logic [7:0]                 output_clock_control;
        logic [7:0]                 gctrl;
        logic [GAMMA_REGS-1:0][7:0] gpts;
        logic                       dv;
        logic [7:0]                 dy;
        logic [7:0]                 dc;
        logic [7:0]                 oc;
        logic [7:0]                 rdata;
        logic                       clk_en;
        lng_br_t                    bst;
        logic [SUM_W-1:0]           sum;
        logic [SUM_W-1:0]           rem;
        logic [CNT_W-1:0]           cnt;
        logic [CNT_W-1:0]           dcnt;
        logic [2:0]                 step;
        logic [7:0]                 quo;
        logic [7:0]                 bright;
    } lng_st_t;

    localparam lng_st_t ST_RST = '{
        gain:    NR_GAIN_RST,
        thr:     NR_THR_RST,
        mode:    NR_MODE_RST,
        output_clock_control:     OCLK_RST,
        gctrl:   GCTRL_RST,
        gpts:    GAMMA_RST,
        bst:     BR_IDLE,
        default: '0
    };

    lng_st_t           st_ff;
    lng_st_t           nxt_st;
    logic              pix;
    logic              vs_fall;
    logic              border;
    logic signed [9:0] hf;
    logic [9:0]        mag;
    logic [9:0]        thr_ext;
    logic [3:0]        graw;
    logic [3:0]        gsel;
    logic [SUM_W-1:0]  trial;

    ////////////////////////////////////////////////////////////////////////
    // Band split: luma minus one of eight low-pass estimates
    function automatic logic signed [9:0] band(input logic [2:0] s,
                                               input logic [7:0] y,
                                               input logic [7:0] a,
                                               input logic [7:0] b);
        logic [9:0] lp;
        lp = {2'b00, y};
        unique case (s)
            3'h0: lp = {2'b00, a};
            3'h1: lp = {2'b00, b};
            3'h2: lp = ({2'b00, a} + {2'b00, b}) >> 1;
            3'h3: lp = ({2'b00, y} + {2'b00, b}) >> 1;
            3'h4: lp = ({2'b00, y} + {1'b0, a, 1'b0} + {2'b00, b}) >> 2;
            3'h5: lp = ({2'b00, a} + {1'b0, b, 1'b0} + {2'b00, b}) >> 2;
            3'h6: lp = ({2'b00, y} + {2'b00, a}) >> 1;
            3'h7: lp = ({1'b0, a, 1'b0} + {2'b00, y} + {2'b00, y}) >> 2;
        endcase
        return $signed({2'b00, y}) - $signed(lp);
    endfunction

    // True when a position lies in the transition band of a block edge
    function automatic logic edge_hit(input logic [3:0] pos,
                                      input logic       big,
                                      input logic       wide);
        logic [3:0] m;
        logic [3:0] w;
        logic [3:0] q;
        m = big ? MASK_BIG : MASK_SMALL;
        w = wide ? EDGE_WIDE : EDGE_NARROW;
        q = pos & m;
        return (q < w) || (q > m - w);
    endfunction

    function automatic logic is_gamma(input logic [ADDR_W-1:0] a);
        return a >= ADDR_GAMMA_0 && a <= ADDR_GAMMA_N;
    endfunction

    function automatic logic [3:0] gidx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - ADDR_GAMMA_0;
        return d[3:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    assign pix     = st_ff.syn2.valid && st_ff.syn2.active;
    assign vs_fall = st_ff.vs_d && !st_ff.syn2.vsync_b;
    assign hf      = band(st_ff.mode[BAND_LSB +: 3], st_ff.syn2.luma,
                          st_ff.p1, st_ff.p2);
    assign mag     = hf[9] ? 10'(-hf) : 10'(hf);
    assign thr_ext = {4'h0, st_ff.thr[THR_LSB +: 6]};
    assign border  = edge_hit(st_ff.hpos, st_ff.thr[BBIG_BIT],
                              st_ff.thr[BWIDE_BIT])
                  || edge_hit(st_ff.vpos, st_ff.thr[BBIG_BIT],
                              st_ff.thr[BWIDE_BIT]);
    assign graw    = border ? st_ff.gain[BGAIN_LSB +: 4]
                            : st_ff.gain[IGAIN_LSB +: 4];
    assign gsel    = (graw > GAIN_MAX) ? GAIN_MAX : graw;
    assign trial   = SUM_W'(st_ff.dcnt) << st_ff.step;

    always_comb begin
        logic signed [15:0] prod;
        logic signed [15:0] corr;
        logic signed [10:0] res;
        prod = hf * $signed({1'b0, gsel});
        corr = prod >>> (st_ff.mode[MODE_BIT] ? SH_SHIFT : NR_SHIFT);
        res  = $signed({3'h0, st_ff.syn2.luma});
        nxt_st = st_ff;

        // Pins pass two flops before use
        nxt_st.syn1  = '{i_pix_valid, i_active, i_vsync_b, i_luma, i_chroma};
        nxt_st.syn2  = st_ff.syn1;
        nxt_st.act_d = st_ff.syn2.active;
        nxt_st.vs_d  = st_ff.syn2.vsync_b;

        // Block grid position
        if (!st_ff.syn2.active) begin
            nxt_st.hpos = st_ff.mode[OFFS_LSB +: 4];
        end else if (st_ff.syn2.valid) begin
            nxt_st.hpos = st_ff.hpos + 4'h1;
        end
        if (vs_fall) begin
            nxt_st.vpos = 4'h0;
        end else if (st_ff.act_d && !st_ff.syn2.active) begin
            nxt_st.vpos = st_ff.vpos + 4'h1;
        end

        // Noise reduction stage
        if (st_ff.syn2.valid) begin
            nxt_st.p1 = st_ff.syn2.luma;
            nxt_st.p2 = st_ff.p1;
        end
        if (pix) begin
            if (!st_ff.mode[MODE_BIT]) begin
                if (mag < thr_ext) begin
                    res = res - corr[10:0];
                end
            end else if (mag > thr_ext) begin
                res = res + corr[10:0];
            end
        end
        nxt_st.dv = st_ff.syn2.valid;
        nxt_st.dc = st_ff.syn2.chroma;
        nxt_st.oc = st_ff.dc;
        if (res[10]) begin
            nxt_st.dy = 8'h00;
        end else if (res[9:8] != 2'b00) begin
            nxt_st.dy = 8'hff;
        end else begin
            nxt_st.dy = res[7:0];
        end

        // Register writes; brightness is read-only
        if (i_reg_wr) begin
            if (is_gamma(i_reg_addr)) begin
                nxt_st.gpts[gidx(i_reg_addr)] = i_reg_wdata;
            end
            case (i_reg_addr)
                ADDR_NR_GAIN: nxt_st.gain  = i_reg_wdata;
                ADDR_NR_THR:  nxt_st.thr   = i_reg_wdata;
                ADDR_NR_MODE: nxt_st.mode  = i_reg_wdata;
                ADDR_OCLK:    nxt_st.output_clock_control   = i_reg_wdata;
                ADDR_GCTRL:   nxt_st.gctrl = i_reg_wdata;
                default:      ;
            endcase
        end
        nxt_st.rdata = 8'h00;
        if (is_gamma(i_reg_addr)) begin
            nxt_st.rdata = st_ff.gpts[gidx(i_reg_addr)];
        end
        case (i_reg_addr)
            ADDR_NR_GAIN: nxt_st.rdata = st_ff.gain;
            ADDR_NR_THR:  nxt_st.rdata = st_ff.thr;
            ADDR_NR_MODE: nxt_st.rdata = st_ff.mode;
            ADDR_BRIGHT:  nxt_st.rdata = st_ff.bright;
            ADDR_OCLK:    nxt_st.rdata = st_ff.output_clock_control;
            ADDR_GCTRL:   nxt_st.rdata = st_ff.gctrl;
            default:      ;
        endcase

        // Clock pin enable needs PLL on and oversampling on
        nxt_st.clk_en = st_ff.output_clock_control[CLKO_BIT] && !i_pll_control_bit
                     && i_oversampling_control_bit;

        // Brightness: sum active luma, divide once per field
        if (pix) begin
            nxt_st.sum = st_ff.sum + {{(SUM_W-8){1'b0}}, st_ff.syn2.luma};
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
        end
        unique case (st_ff.bst)
            BR_IDLE: begin
                if (vs_fall) begin
                    nxt_st.rem  = st_ff.sum;
                    nxt_st.dcnt = st_ff.cnt;
                    nxt_st.step = DIV_TOP;
                    nxt_st.quo  = 8'h00;
                    nxt_st.sum  = '0;
                    nxt_st.cnt  = '0;
                    nxt_st.bst  = BR_DIV;
                end
            end
            BR_DIV: begin
                if (st_ff.rem >= trial) begin
                    nxt_st.rem = st_ff.rem - trial;
                    nxt_st.quo[st_ff.step] = 1'b1;
                end
                if (st_ff.step == 3'h0) begin
                    nxt_st.bright = (st_ff.dcnt == '0) ? 8'h00
                                                       : nxt_st.quo;
                    nxt_st.bst    = BR_IDLE;
                end else begin
                    nxt_st.step = st_ff.step - 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    lng_gamma u_gamma (
        .i_mclk   (i_mclk),
        .i_rst_b  (i_rst_b),
        .i_valid  (st_ff.dv),
        .i_luma   (st_ff.dy),
        .i_enable (st_ff.gctrl[GEN_BIT]),
        .i_sel_curve (st_ff.gctrl[GSEL_BIT]),
        .i_points (st_ff.gpts),
        .o_valid  (o_valid),
        .o_luma   (o_luma)
    );

    assign o_chroma           = st_ff.oc;
    assign o_reg_rdata        = st_ff.rdata;
    assign o_clock_out_enable = st_ff.clk_en;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_ocr_set;
        i_reg_wr && i_reg_addr == ADDR_OCLK && i_reg_wdata[CLKO_BIT];
    endsequence

    sequence s_pll_ok;
        !i_pll_control_bit && i_oversampling_control_bit;
    endsequence

    sequence s_vs_fall;
        vs_fall && st_ff.bst == BR_IDLE;
    endsequence

    a_clock_output_pin_on: assert property (
        s_ocr_set ##1 s_pll_ok |=> o_clock_out_enable)
        else $error("clock output not enabled");

    a_clock_output_pin_gate: assert property (
        (i_pll_control_bit || !i_oversampling_control_bit)
        |=> !o_clock_out_enable)
        else $error("clock output enabled without PLL");

    a_nr_keep: assert property (
        (pix && !st_ff.mode[MODE_BIT] && mag >= thr_ext)
        |=> st_ff.dy == $past(st_ff.syn2.luma))
        else $error("detail above threshold was cored");

    a_sh_keep: assert property (
        (pix && st_ff.mode[MODE_BIT] && mag <= thr_ext)
        |=> st_ff.dy == $past(st_ff.syn2.luma))
        else $error("noise below threshold was sharpened");

    a_gain_zero: assert property (
        (pix && gsel == 4'h0) |=> st_ff.dy == $past(st_ff.syn2.luma))
        else $error("zero gain changed luma");

    a_chroma_pass: assert property (
        st_ff.syn2.valid |-> ##2 o_chroma == $past(st_ff.syn2.chroma, 2))
        else $error("chroma altered");

    a_grid_offset: assert property (
        !st_ff.syn2.active |=> st_ff.hpos == $past(st_ff.mode[OFFS_LSB +: 4]))
        else $error("block grid not reloaded with offset");

    a_bright_div: assert property (
        s_vs_fall |=> (st_ff.bst == BR_DIV)[*8] ##1 st_ff.bst == BR_IDLE)
        else $error("brightness update not finished in nine cycles");

    a_bright_src: assert property (
        $changed(st_ff.bright) |-> $past(st_ff.bst == BR_DIV))
        else $error("brightness changed outside field update");

    a_reg_back: assert property (
        (i_reg_wr && i_reg_addr == ADDR_GAMMA_0)
        ##1 (!i_reg_wr && i_reg_addr == ADDR_GAMMA_0)
        |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("gamma point readback mismatch");

endmodule

/* File: lng_src.sv */
// Behavioural video source driving strobed luma and chroma pixels
`timescale 1ns/100ps
module lng_src (
    input  wire logic       i_mclk,
    output var  logic       o_valid,
    output var  logic       o_active,
    output var  logic       o_vsync_b,
    output var  logic [7:0] o_luma,
    output var  logic [7:0] o_chroma
);
    initial begin
        o_valid   = 1'b0;
        o_active  = 1'b0;
        o_vsync_b = 1'b1;
        o_luma    = 8'h00;
        o_chroma  = 8'h00;
    end

    // One strobed pixel; data lines are scrambled once the hold runs out
    task automatic send(input logic [7:0] y, c, input logic a);
        @(negedge i_mclk);
        o_luma   = y;
        o_chroma = c;
        o_active = a;
        o_valid  = 1'b1;
        @(negedge i_mclk);
        o_valid = 1'b0;
        repeat (3) @(negedge i_mclk);
        o_luma   = ~y;
        o_chroma = ~c;
    endtask

    // Vertical sync pulse closing a field
    task automatic field_end();
        @(negedge i_mclk);
        o_active  = 1'b0;
        o_vsync_b = 1'b0;
        repeat (4) @(negedge i_mclk);
        o_vsync_b = 1'b1;
    endtask
endmodule

/* File: tb.sv */
// Register and pixel stream testbench for the luma stage
`timescale 1ns/100ps
module tb;
    import lng_pkg::*;
    logic       clk, rst_b, wr, pll, ovs;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       s_valid, s_active, s_vsync_b, o_valid, clko;
    logic [7:0] s_luma, s_chroma, o_luma, o_chroma, rdata;
    int         error_cnt, checks_done;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    lng_src src_inst (.i_mclk(clk), .o_valid(s_valid), .o_active(s_active),
        .o_vsync_b(s_vsync_b), .o_luma(s_luma), .o_chroma(s_chroma));

    lng_top lng_top_inst (.i_mclk(clk), .i_rst_b(rst_b),
        .i_pix_valid(s_valid), .i_active(s_active), .i_vsync_b(s_vsync_b),
        .i_luma(s_luma), .i_chroma(s_chroma), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_pll_control_bit(pll),
        .i_oversampling_control_bit(ovs), .o_valid(o_valid),
        .o_luma(o_luma), .o_chroma(o_chroma), .o_reg_rdata(rdata),
        .o_clock_out_enable(clko));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp,
                          input string nm);
        @(negedge clk);
        addr = a;
        repeat (2) @(negedge clk);
        chk(nm, exp, rdata);
    endtask

    task automatic pix(input logic [7:0] y, c, input logic a,
                       input logic [7:0] ey, input bit ck);
        int n;
        n = 0;
        fork
            src_inst.send(y, c, a);
            do begin
                @(negedge clk);
                n++;
            end while (o_valid !== 1'b1 && n < 12);
        join
        chk("pixel latency", 8'h05, 8'(n));
        if (ck) begin
            chk("pixel luma", ey, o_luma);
            chk("pixel chroma", c, o_chroma);
        end
    endtask

    task automatic clko_chk(input string nm, input logic e);
        repeat (3) @(negedge clk);
        chk(nm, {7'h00, e}, {7'h00, clko});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        error_cnt = 0;
        checks_done = 0;
        rst_b = 1'b0;
        addr = 6'h00;
        wdata = 8'h00;
        wr = 1'b0;
        pll = 1'b1;
        ovs = 1'b1;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        rd_reg(ADDR_OCLK, OCLK_RST, "clock reg reset");
        rd_reg(ADDR_GAMMA_0, 8'h20, "first point reset");
        rd_reg(ADDR_GAMMA_N, 8'he0, "last point reset");
        rd_reg(ADDR_BRIGHT, 8'h00, "brightness reset");
        pix(8'h0a, 8'h11, 1'b1, 8'h0a, 1'b1);
        pix(8'h14, 8'h12, 1'b1, 8'h14, 1'b1);
        pix(8'h1e, 8'h13, 1'b1, 8'h1e, 1'b1);
        pix(8'hc8, 8'h14, 1'b0, 8'hc8, 1'b1);
        src_inst.field_end();
        repeat (14) @(negedge clk);
        rd_reg(ADDR_BRIGHT, 8'h14, "brightness mean");
        wr_reg(ADDR_BRIGHT, 8'hff);
        rd_reg(ADDR_BRIGHT, 8'h14, "brightness read only");
        rd_reg(6'h3f, 8'h00, "unmapped read");
        pll = 1'b0;
        wr_reg(ADDR_OCLK, 8'h7a);
        clko_chk("clock out on", 1'b1);
        pll = 1'b1;
        clko_chk("clock out pll off", 1'b0);
        pll = 1'b0;
        ovs = 1'b0;
        clko_chk("clock out no oversampling", 1'b0);
        ovs = 1'b1;
        clko_chk("clock out back on", 1'b1);
        wr_reg(ADDR_OCLK, 8'h78);
        clko_chk("clock out off", 1'b0);
        wr_reg(ADDR_GAMMA_0, 8'h30);
        wr_reg(ADDR_GCTRL, 8'h01);
        pix(8'h18, 8'h55, 1'b0, 8'h20, 1'b1);
        pix(8'hfa, 8'h56, 1'b0, 8'hfa, 1'b1);
        pix(8'h08, 8'h57, 1'b0, 8'h08, 1'b1);
        wr_reg(ADDR_GCTRL, 8'h03);
        pix(8'h18, 8'h58, 1'b0, 8'h18, 1'b1);
        wr_reg(ADDR_GCTRL, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr_reg(ADDR_NR_GAIN, 8'h88);
            wr_reg(ADDR_NR_THR, {i[1:0], 6'h3f});
            wr_reg(ADDR_NR_MODE, {i[3:0], i[3], i[2:0]});
            rd_reg(ADDR_NR_MODE, {i[3:0], i[3], i[2:0]}, "mode reg");
            repeat (3) pix(8'h64, 8'h22, 1'b1, 8'h64, 1'b0);
            pix(8'h64, 8'h22, 1'b1, 8'h64, 1'b1);
        end
        // Row position is zero since the field start, so border gain rules
        wr_reg(ADDR_NR_GAIN, 8'h08);
        wr_reg(ADDR_NR_THR, 8'h3f);
        wr_reg(ADDR_NR_MODE, 8'h00);
        pix(8'h64, 8'h26, 1'b1, 8'h64, 1'b0);
        pix(8'h6e, 8'h27, 1'b1, 8'h64, 1'b1);
        wr_reg(ADDR_NR_GAIN, 8'h88);
        wr_reg(ADDR_NR_THR, 8'h05);
        wr_reg(ADDR_NR_MODE, 8'h08);
        pix(8'h64, 8'h28, 1'b1, 8'h64, 1'b0);
        pix(8'h6e, 8'h29, 1'b1, 8'h73, 1'b1);
        wrap_up();
    end
endmodule
